// ===== asf_pkg.sv
package asf_pkg;
	// ****************************************************************
	// Geometry of the address index register
	// ****************************************************************
	localparam int unsigned SUB_COUNT = 16;
	localparam int unsigned SUB_W = 16;
	localparam int unsigned IDX_W = 12;
	localparam int unsigned CNT_W = 5;
	typedef logic [3:0] asf_sub_idx_t;
	typedef logic [CNT_W-1:0] asf_cnt_t;
	typedef logic [SUB_COUNT-1:0][SUB_W-1:0] asf_vec_t;

	// Descriptor halves by subregister number
	localparam asf_sub_idx_t DESC_LO_SUB = 4'h0;
	localparam asf_sub_idx_t DESC_HI_SUB = 4'h1;
	localparam asf_sub_idx_t EXDESC_LO_SUB = 4'h2;
	localparam asf_sub_idx_t EXDESC_HI_SUB = 4'h3;
	// Response layout: second index sits in element 1, extended descriptor in elements 2..3
	localparam asf_sub_idx_t RSP_IDX1_ELEM = 4'h1;
	localparam asf_sub_idx_t RSP_EXT_LO_ELEM = 4'h2;
	localparam asf_sub_idx_t RSP_EXT_HI_ELEM = 4'h3;

	typedef enum logic [1:0] {
		ASF_OP_READ,
		ASF_OP_WRITE,
		ASF_OP_INDEX,
		ASF_OP_SEND
	} asf_op_t;

	// ****************************************************************
	// Scoreboard timing: cycles from write acceptance to retirement
	// ****************************************************************
	localparam int unsigned WB_LAT = 3;
	typedef logic [1:0] asf_lat_t;
	localparam asf_lat_t WB_LAT_CNT = asf_lat_t'(WB_LAT);
	localparam asf_lat_t LAT_LAST = 2'h1;

	// ****************************************************************
	// Controller registers on AXI4-Lite
	// ****************************************************************
	localparam int unsigned AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_WDATA = 8'h04;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [AXI_AW-1:0] REG_RES0 = 8'h0c;
	localparam logic [AXI_AW-1:0] REG_RES1 = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// CTRL fields
	localparam int unsigned CTRL_OP_LSB = 0;
	localparam int unsigned CTRL_START_LSB = 4;
	localparam int unsigned CTRL_COUNT_LSB = 8;
	localparam int unsigned CTRL_STRIDE_BIT = 13;
	localparam int unsigned CTRL_SKIP_CHK_BIT = 14;
	localparam int unsigned CTRL_SKIP_CLR_BIT = 15;
	localparam int unsigned CTRL_PAIR_BIT = 16;
	localparam int unsigned CTRL_DESC_OK_BIT = 17;
	// WDATA fields: element value low, element write mask high
	localparam int unsigned WDATA_MASK_LSB = 16;
	// STATUS fields
	localparam int unsigned STAT_PEND_BIT = 0;
	localparam int unsigned STAT_ERR_BIT = 1;
endpackage

// ===== asf_if.sv
interface asf_if;
	import asf_pkg::*;
	logic req_valid;
	logic req_ready;
	asf_op_t req_op;
	asf_sub_idx_t req_start;
	asf_cnt_t req_count;
	logic req_stride;
	logic req_skip_check;
	logic req_skip_clear;
	logic req_pair;
	logic req_desc_ok;
	logic [SUB_COUNT-1:0] req_mask;
	asf_vec_t req_data;
	logic rsp_valid;
	logic rsp_err;
	asf_vec_t rsp_data;

	modport dev (
		input req_valid, req_op, req_start, req_count, req_stride, req_skip_check,
		input req_skip_clear, req_pair, req_desc_ok, req_mask, req_data,
		output req_ready, rsp_valid, rsp_err, rsp_data
	);
	modport host (
		output req_valid, req_op, req_start, req_count, req_stride, req_skip_check,
		output req_skip_clear, req_pair, req_desc_ok, req_mask, req_data,
		input req_ready, rsp_valid, rsp_err, rsp_data
	);
endinterface

// ===== asf_dev.sv
module asf_dev (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	asf_if.dev LINK,
	output logic O_SB_BUSY,
	output logic O_FAULT
);
	import asf_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		asf_vec_t sub;
		logic busy;
		asf_lat_t lat;
		logic ready;
		logic rsp_valid;
		logic rsp_err;
		asf_vec_t rsp_data;
		logic fault;
	} asf_dev_state_t;

	asf_dev_state_t st;
	asf_dev_state_t next_st;

	logic take;
	asf_sub_idx_t elem;
	asf_sub_idx_t start_odd;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		next_st.rsp_valid = 1'b0;
		next_st.rsp_err = 1'b0;
		next_st.fault = 1'b0;
		elem = '0;
		start_odd = '0;
		// Skip-check requests are taken even while the scoreboard is held
		take = LINK.req_valid && (st.ready || LINK.req_skip_check);

		// Retirement of the in-flight write releases the single scoreboard
		if (st.busy) begin
			if (st.lat == LAT_LAST) begin
				next_st.busy = 1'b0;
			end else begin
				next_st.lat = st.lat - LAT_LAST;
			end
		end

		if (take) begin
			next_st.rsp_valid = 1'b1;
			next_st.rsp_data = '0;
			unique case (LINK.req_op)
				ASF_OP_READ: begin
					// Stride zero replicates the start subregister over the region
					for (int i = 0; i < SUB_COUNT; i++) begin
						elem = LINK.req_start + (LINK.req_stride ? asf_sub_idx_t'(i) : '0);
						if (asf_cnt_t'(i) < LINK.req_count) begin
							next_st.rsp_data[i] = st.sub[elem];
						end
					end
				end
				ASF_OP_WRITE: begin
					// Source stride zero replicates element 0 into every target
					for (int i = 0; i < SUB_COUNT; i++) begin
						elem = LINK.req_start + asf_sub_idx_t'(i);
						if (asf_cnt_t'(i) < LINK.req_count && LINK.req_mask[i]) begin
							next_st.sub[elem] = LINK.req_stride ? LINK.req_data[i] :
								LINK.req_data[0];
						end
					end
					// A write marks the whole register busy unless told not to
					if (!LINK.req_skip_clear) begin
						next_st.busy = 1'b1;
						next_st.lat = WB_LAT_CNT;
					end
				end
				ASF_OP_INDEX: begin
					start_odd = LINK.req_start + asf_sub_idx_t'(1);
					next_st.rsp_data[0] = {{(SUB_W-IDX_W){1'b0}},
						st.sub[LINK.req_start][IDX_W-1:0]};
					if (LINK.req_pair) begin
						next_st.rsp_data[RSP_IDX1_ELEM] = {{(SUB_W-IDX_W){1'b0}},
							st.sub[start_odd][IDX_W-1:0]};
						// A pair must share one dword; odd starts straddle two
						next_st.rsp_err = LINK.req_start[0];
					end
				end
				ASF_OP_SEND: begin
					next_st.rsp_data[0] = st.sub[DESC_LO_SUB];
					next_st.rsp_data[1] = st.sub[DESC_HI_SUB];
					// Extended descriptor from dword 1, or from dword 0 when not paired
					if (LINK.req_pair) begin
						next_st.rsp_data[RSP_EXT_LO_ELEM] = st.sub[EXDESC_LO_SUB];
						next_st.rsp_data[RSP_EXT_HI_ELEM] = st.sub[EXDESC_HI_SUB];
					end else begin
						next_st.rsp_data[RSP_EXT_LO_ELEM] = st.sub[DESC_LO_SUB];
						next_st.rsp_data[RSP_EXT_HI_ELEM] = st.sub[DESC_HI_SUB];
					end
					// Descriptor operand not in scalar dword-0 form is flagged only
					next_st.rsp_err = !LINK.req_desc_ok;
				end
			endcase
			next_st.fault = next_st.rsp_err;
		end

		// Ready is registered, so a write stalls the next cycle's reads and writes
		next_st.ready = !next_st.busy;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Contents have no defined power-on value; zero keeps simulation clean
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// The packed vector layout puts subregister 2n low and 2n+1 high in dword n
	assign LINK.req_ready = st.ready;
	assign LINK.rsp_valid = st.rsp_valid;
	assign LINK.rsp_err = st.rsp_err;
	assign LINK.rsp_data = st.rsp_data;
	assign O_SB_BUSY = st.busy;
	assign O_FAULT = st.fault;
endmodule

// ===== asf_host.sv
// The AXI4-Lite slave port is this design's own decision.
module asf_host (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	asf_if.host LINK,
	input wire logic I_AWVALID,
	input wire logic [asf_pkg::AXI_AW-1:0] I_AWADDR,
	output logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_WREADY,
	output logic O_BVALID,
	output logic [1:0] O_BRESP,
	input wire logic I_BREADY,
	input wire logic I_ARVALID,
	input wire logic [asf_pkg::AXI_AW-1:0] I_ARADDR,
	output logic O_ARREADY,
	output logic O_RVALID,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic I_RREADY
);
	import asf_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [AXI_AW-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] ctrl;
		logic [31:0] wdata;
		logic req_valid;
		logic pending;
		logic err;
		logic [31:0] res0;
		logic [31:0] res1;
	} asf_host_state_t;

	asf_host_state_t st;
	asf_host_state_t next_st;
	logic [31:0] merged;
	logic [31:0] old_val;

	always_comb begin
		next_st = st;
		merged = '0;
		old_val = (st.aw_addr == REG_CTRL) ? st.ctrl : st.wdata;
		// Write address and data are taken in either order
		if (I_AWVALID && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = I_AWADDR;
			next_st.awready = 1'b0;
		end
		if (I_WVALID && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = I_WDATA;
			next_st.w_strb = I_WSTRB;
			next_st.wready = 1'b0;
		end
		if (st.bvalid && I_BREADY) begin
			next_st.bvalid = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			for (int b = 0; b < 4; b++) begin
				merged[b*8 +: 8] = st.w_strb[b] ? st.w_data[b*8 +: 8] : old_val[b*8 +: 8];
			end
			if (st.aw_addr == REG_CTRL) begin
				// One operation at a time: a new command while one is pending is refused
				if (st.pending) begin
					next_st.bresp = RESP_SLVERR;
				end else begin
					next_st.ctrl = merged;
					next_st.req_valid = 1'b1;
					next_st.pending = 1'b1;
				end
			end else if (st.aw_addr == REG_WDATA) begin
				next_st.wdata = merged;
			end else if (st.aw_addr != REG_STATUS && st.aw_addr != REG_RES0 &&
				st.aw_addr != REG_RES1) begin
				next_st.bresp = RESP_DECERR;
			end
		end

		if (I_ARVALID && st.arready) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			unique case (I_ARADDR)
				REG_CTRL: next_st.rdata = st.ctrl;
				REG_WDATA: next_st.rdata = st.wdata;
				REG_STATUS: begin
					next_st.rdata = '0;
					next_st.rdata[STAT_PEND_BIT] = st.pending;
					next_st.rdata[STAT_ERR_BIT] = st.err;
				end
				REG_RES0: next_st.rdata = st.res0;
				REG_RES1: next_st.rdata = st.res1;
				default: begin
					next_st.rdata = '0;
					next_st.rresp = RESP_DECERR;
				end
			endcase
		end
		if (st.rvalid && I_RREADY) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end

		// Request held until taken; a skip-check request needs no ready
		if (st.req_valid && (LINK.req_ready || st.ctrl[CTRL_SKIP_CHK_BIT])) begin
			next_st.req_valid = 1'b0;
		end
		if (LINK.rsp_valid) begin
			next_st.pending = 1'b0;
			next_st.err = LINK.rsp_err;
			next_st.res0 = {LINK.rsp_data[1], LINK.rsp_data[0]};
			next_st.res1 = {LINK.rsp_data[3], LINK.rsp_data[2]};
		end
	end

	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st <= '0;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Alignment of indices and descriptor form are software's duty, passed through
	assign LINK.req_valid = st.req_valid;
	assign LINK.req_op = asf_op_t'(st.ctrl[CTRL_OP_LSB +: 2]);
	assign LINK.req_start = st.ctrl[CTRL_START_LSB +: 4];
	assign LINK.req_count = st.ctrl[CTRL_COUNT_LSB +: CNT_W];
	assign LINK.req_stride = st.ctrl[CTRL_STRIDE_BIT];
	assign LINK.req_skip_check = st.ctrl[CTRL_SKIP_CHK_BIT];
	assign LINK.req_skip_clear = st.ctrl[CTRL_SKIP_CLR_BIT];
	assign LINK.req_pair = st.ctrl[CTRL_PAIR_BIT];
	assign LINK.req_desc_ok = st.ctrl[CTRL_DESC_OK_BIT];
	assign LINK.req_mask = st.wdata[WDATA_MASK_LSB +: SUB_COUNT];
	assign LINK.req_data = {SUB_COUNT{st.wdata[SUB_W-1:0]}};
	assign O_AWREADY = st.awready;
	assign O_WREADY = st.wready;
	assign O_BVALID = st.bvalid;
	assign O_BRESP = st.bresp;
	assign O_ARREADY = st.arready;
	assign O_RVALID = st.rvalid;
	assign O_RDATA = st.rdata;
	assign O_RRESP = st.rresp;
endmodule

// ===== asf_properties.sv
module asf_properties (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire asf_pkg::asf_op_t req_op,
	input wire asf_pkg::asf_sub_idx_t req_start,
	input wire asf_pkg::asf_cnt_t req_count,
	input wire logic req_stride,
	input wire logic req_skip_check,
	input wire logic req_skip_clear,
	input wire logic req_pair,
	input wire logic req_desc_ok,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire asf_pkg::asf_vec_t rsp_data
);
	import asf_pkg::*;
	// ****************************************************************
	// Request taken; skip_check bypasses the scoreboard
	// ****************************************************************
	logic take;
	assign take = req_valid && (req_ready || req_skip_check);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_ARST_N);
	sequence s_take(asf_op_t o);
		take && req_op == o;
	endsequence
	sequence s_hold;
		take && req_op == ASF_OP_WRITE && !req_skip_clear;
	endsequence
	AST_RSP_NEXT: assert property (take |=> rsp_valid)
		else $error("no response after request");
	AST_WR_STALL: assert property (s_hold |=> !req_ready [*3])
		else $error("ready during write in flight");
	AST_WR_RETIRE: assert property (s_hold |-> ##4 req_ready)
		else $error("scoreboard not released");
	AST_RD_STALL: assert property (req_valid && !req_ready && !req_skip_check |=> !rsp_valid)
		else $error("request served while stalled");
	AST_CLR_SKIP: assert property (
		take && req_op == ASF_OP_WRITE && req_skip_clear && req_ready |=> req_ready)
		else $error("skip_clear write held scoreboard");
	AST_IDX_12BIT: assert property (
		s_take(ASF_OP_INDEX) |=> rsp_data[0][15:12] == 4'h0 && rsp_data[1][15:12] == 4'h0)
		else $error("index wider than 12 bits");
	AST_IDX_MISALIGN: assert property (
		take && req_op == ASF_OP_INDEX && req_pair && req_start[0] |=> rsp_err)
		else $error("odd index pair not flagged");
	AST_DESC_BAD: assert property (take && req_op == ASF_OP_SEND && !req_desc_ok |=> rsp_err)
		else $error("bad descriptor not flagged");
	AST_EXT_FROM_DESC: assert property (
		take && req_op == ASF_OP_SEND && !req_pair |=> rsp_data[2] == rsp_data[0]
		&& rsp_data[3] == rsp_data[1])
		else $error("extended descriptor not from subs 0 and 1");
	AST_RD_REPL: assert property (
		take && req_op == ASF_OP_READ && !req_stride && req_count == 5'h10
		|=> rsp_data == {SUB_COUNT{rsp_data[0]}})
		else $error("replicated read differs");
endmodule

// ===== asf_tb.sv
module asf_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import asf_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, r0, r1, st;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, sb_busy, fault;
	logic [1:0] bresp, rresp;
	logic [15:0] m [16];
	int n_errors = 0, compares = 0, run = 0, n_busy = 0, n_fault = 0, n_stall = 0;
	asf_if lnk();
	always #12.5 mclk = ~mclk;
	asf_dev asf_dev_i (.I_MCLK(mclk), .I_ARST_N(arst_n), .LINK(lnk.dev), .O_SB_BUSY(sb_busy),
		.O_FAULT(fault));
	asf_host asf_host_i (.I_MCLK(mclk), .I_ARST_N(arst_n), .LINK(lnk.host),
		.I_AWVALID(awvalid), .I_AWADDR(awaddr), .O_AWREADY(awready), .I_WVALID(wvalid),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .O_WREADY(wready), .O_BVALID(bvalid),
		.O_BRESP(bresp), .I_BREADY(bready), .I_ARVALID(arvalid), .I_ARADDR(araddr),
		.O_ARREADY(arready), .O_RVALID(rvalid), .O_RDATA(rdata), .O_RRESP(rresp),
		.I_RREADY(rready));
	asf_properties asf_properties_i (.I_MCLK(mclk), .I_ARST_N(arst_n),
		.req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_op(lnk.req_op),
		.req_start(lnk.req_start), .req_count(lnk.req_count), .req_stride(lnk.req_stride),
		.req_skip_check(lnk.req_skip_check), .req_skip_clear(lnk.req_skip_clear),
		.req_pair(lnk.req_pair), .req_desc_ok(lnk.req_desc_ok), .rsp_valid(lnk.rsp_valid),
		.rsp_err(lnk.rsp_err), .rsp_data(lnk.rsp_data));
	// ****************************************************************
	// Checking and bus tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Each task starts on a fresh edge so no signal is assigned twice in one step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge mclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'(e), 32'(bresp));
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	// Flags f: stride, skip_check, skip_clear, pair, desc_ok from the stride bit up
	function automatic logic [31:0] ctl(asf_op_t o, int s, int c, logic [4:0] f);
		return 32'(o) | 32'(s) << CTRL_START_LSB | 32'(c) << CTRL_COUNT_LSB
			| 32'(f) << CTRL_STRIDE_BIT;
	endfunction
	task automatic run_op(input logic [31:0] c, input logic [31:0] w, input logic e);
		logic [1:0] rs;
		axi_wr(REG_WDATA, w, RESP_OKAY);
		axi_wr(REG_CTRL, c, RESP_OKAY);
		do axi_rd(REG_STATUS, st, rs); while (st[STAT_PEND_BIT] !== 1'b0);
		chk("err", 32'(e), 32'(st[STAT_ERR_BIT]));
		axi_rd(REG_RES0, r0, rs);
		axi_rd(REG_RES1, r1, rs);
	endtask
	// Second command offered in the step the first response is taken, bready held high
	task automatic ctrl_pair(input logic [31:0] c0, input logic [31:0] c1);
		@(posedge mclk);
		awvalid <= 1'b1;
		awaddr <= REG_CTRL;
		wvalid <= 1'b1;
		wdata <= c0;
		bready <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			do begin
				@(posedge mclk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (bvalid !== 1'b1);
			chk("bresp_pair", 32'(RESP_OKAY), 32'(bresp));
			if (k == 0) begin
				awvalid <= 1'b1;
				wvalid <= 1'b1;
				wdata <= c1;
			end
		end
		bready <= 1'b0;
	endtask
	// Busy runs must last exactly the in-flight time
	always @(posedge mclk) begin
		if (fault === 1'b1) n_fault++;
		// Requests held back by the scoreboard, skip-check ones excluded
		if (lnk.req_valid === 1'b1 && lnk.req_ready === 1'b0 &&
			lnk.req_skip_check === 1'b0) n_stall++;
		if (sb_busy === 1'b1) begin
			if (run == 0) n_busy++;
			run++;
		end else if (run != 0) begin
			chk("busy_run", WB_LAT, 32'(run));
			run = 0;
		end
	end
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		end_sim();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [31:0] d;
		logic [1:0] rs;
		logic [15:0] v;
		logic [31:0] c;
		void'($urandom(45));
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		axi_rd(REG_RES1, d, rs);
		chk("res1_reset", 32'h0, d);
		axi_rd(8'h14, d, rs);
		chk("rresp_unmapped", 32'(RESP_DECERR), 32'(rs));
		axi_wr(8'h14, 32'h0, RESP_DECERR);
		axi_wr(REG_STATUS, 32'hffffffff, RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			v = 16'($urandom);
			m[i] = v;
			run_op(ctl(ASF_OP_WRITE, i, 1, 5'h01), {16'h0001, v}, 1'b0);
		end
		// Wrapping masked group write: elements 0,1,3 land on subs 14,15,1
		v = 16'($urandom);
		run_op(ctl(ASF_OP_WRITE, 14, 4, 5'h00), {16'h000b, v}, 1'b0);
		m[14] = v;
		m[15] = v;
		m[1] = v;
		v = 16'($urandom);
		run_op(ctl(ASF_OP_WRITE, 5, 1, 5'h05), {16'h0001, v}, 1'b0);
		m[5] = v;
		for (int i = 0; i < 16; i += 2) begin
			run_op(ctl(ASF_OP_READ, i, 2, (i == 0) ? 5'h03 : 5'h01), 32'h0, 1'b0);
			chk("rd_dword", {m[i + 1], m[i]}, r0);
			chk("rd_unused", 32'h0, r1);
		end
		run_op(ctl(ASF_OP_READ, 4, 16, 5'h00), 32'h0, 1'b0);
		chk("rd_repl", {m[4], m[4]}, r1);
		for (int i = 0; i < 16; i++) begin
			run_op(ctl(ASF_OP_INDEX, i, 2, 5'h08), 32'h0, i[0]);
			chk("index", {4'h0, m[(i + 1) % 16][11:0], 4'h0, m[i][11:0]}, r0);
		end
		for (int k = 0; k < 4; k++) begin
			run_op(ctl(ASF_OP_SEND, 0, 1, 5'(k * 8)), 32'h0, !k[1]);
			chk("desc", {m[1], m[0]}, r0);
			chk("exdesc", k[0] ? {m[3], m[2]} : {m[1], m[0]}, r1);
		end
		// Second command meets a write in flight: stalled read, skip-check read, stalled write
		for (int k = 0; k < 3; k++) begin
			v = 16'($urandom);
			axi_wr(REG_WDATA, {16'h0001, v}, RESP_OKAY);
			c = ctl((k == 2) ? ASF_OP_WRITE : ASF_OP_READ, 6 + k / 2, 2 - k / 2,
				(k == 1) ? 5'h03 : 5'h01);
			ctrl_pair(ctl(ASF_OP_WRITE, 6, 1, 5'h01), c);
			m[6] = v;
			if (k == 2) m[7] = v;
			do axi_rd(REG_STATUS, st, rs); while (st[STAT_PEND_BIT] !== 1'b0);
			if (k == 2) run_op(ctl(ASF_OP_READ, 6, 2, 5'h01), 32'h0, 1'b0);
			else axi_rd(REG_RES0, r0, rs);
			chk("wr_then_rd", {m[7], m[6]}, r0);
		end
		chk("stall_count", 32'h2, 32'(n_stall));
		chk("busy_count", 32'h15, 32'(n_busy));
		chk("fault_count", 32'ha, 32'(n_fault));
		end_sim();
	end
endmodule
